/* File: logic/route_cfg_regs.sv */
// Capability words and route-table configuration registers of the switch.
//
// Overview of operation
// - Source operations word reads one at bit 2: event writes supported.
// - Source operations bits 4 to 8, indivisible operations, read zero.
// - Source operations bits 10 to 15 read zero; other bits reserved.
// - Group-cast support word bit 31 reads zero; basic model unsupported.
// - Route limit word returns 0xff in bits 15 to 0, meaning 256 IDs.
// - Group-cast info bits 15 to 0 return mask count 0x0028.
// - Group-cast info bits 29 to 16 return IDs per mask 0x00ff.
// - Group-cast info bits 30 and 31 read zero: associations unsupported.
// - Initializer ID, bits 15 to 0, read-write, resets to 0xffff.
// - Device label is a 32-bit read-write register resetting to zero.
// - Select bits 7 to 0 hold the low destination ID byte.
// - Select bits 15 to 8 hold the high destination ID byte.
// - Select bits 19 to 16 pick one port's route table, nonstandard.
// - Select bit 31 is the extended route configuration enable.
// - Port-select byte 0 holds the egress for the selected ID.
// - Port-select bytes 1 to 3 hold egress for ID plus one to three.
// - Switch port info bits 31 to 16 are reserved.
// - Port info low byte gives ingress port, or 0xfe over two-wire.
// - Port info bits 15 to 8 give the fixed port total 0x10.
`include "route_cfg_defines.svh"

module route_cfg_regs #(
  parameter int TBL_DEPTH = 256,
  parameter int NUM_PORT_TBLS = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire route_cfg_pkg::reg_req_t req,
  output route_cfg_pkg::reg_rsp_t rsp,
  output route_cfg_pkg::route_sel_t route_sel,
  output logic [15:0] initializer_id,
  output logic [31:0] device_label,
  input wire logic [7:0] lookup_id,
  input wire logic [3:0] lookup_table,
  output logic [7:0] lookup_egress
);

  localparam int ENTRIES = `ROUTE_ENTRIES_PER_WORD;
  localparam int TOTAL = TBL_DEPTH * NUM_PORT_TBLS;

  // Reset synchroniser. The reset takes hold at once when resetn falls,
  // but its release waits two clock edges so that no flop leaves reset
  // close to an edge; requests in those two cycles are lost.
  logic rst_sync1_q;
  logic rst_n_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync1_q <= 1'h0;
      rst_n_q <= 1'h0;
    end else begin
      rst_sync1_q <= 1'h1;
      rst_n_q <= rst_sync1_q;
    end
  end

  // Writable register state. The high ID byte and the extended enable are
  // stored and exported only; entry indexing uses the low byte.
  logic [15:0] initializer_id_q;
  logic [31:0] device_label_q;
  logic [7:0] sel_low_q;
  logic [7:0] sel_high_q;
  logic [3:0] sel_port_tbl_q;
  logic sel_ext_en_q;

  // Route storage, one table of entries per port table selector. Every
  // entry clears on reset, so a table reads zero until software fills it.
  logic [7:0] route_tbl [TOTAL];

  // Address decode, one named strobe per register. The whole offset is
  // compared, so no register appears at a second address.
  logic hit_port_info;
  logic hit_src_ops;
  logic hit_gc_support;
  logic hit_id_limit;
  logic hit_gc_info;
  logic hit_init_id;
  logic hit_label;
  logic hit_id_sel;
  logic hit_port_sel;

  assign hit_port_info = (req.addr == `OFS_SWITCH_PORT_INFO);
  assign hit_src_ops = (req.addr == `OFS_SOURCE_OPS_CAPS);
  assign hit_gc_support = (req.addr == `OFS_GROUP_CAST_SUPPORT_CAPS);
  assign hit_id_limit = (req.addr == `OFS_ROUTE_ID_LIMIT_CAPS);
  assign hit_gc_info = (req.addr == `OFS_GROUP_CAST_INFO_CAPS);
  assign hit_init_id = (req.addr == `OFS_INITIALIZER_ID_LOCK);
  assign hit_label = (req.addr == `OFS_DEVICE_LABEL);
  assign hit_id_sel = (req.addr == `OFS_ROUTE_CFG_ID_SELECT);
  assign hit_port_sel = (req.addr == `OFS_ROUTE_CFG_PORT_SELECT);

  // Write strobes; the fixed words have none at all, which is what keeps
  // a write to a capability word from having any effect.
  logic wr_init_id;
  logic wr_label;
  logic wr_id_sel;
  logic wr_port_sel;

  assign wr_init_id = req.wr && hit_init_id;
  assign wr_label = req.wr && hit_label;
  assign wr_id_sel = req.wr && hit_id_sel;
  assign wr_port_sel = req.wr && hit_port_sel;

  // Fixed capability words. They are built from constants, the port info word also from the request, and hold no
  // state, so they need no reset and a write cannot change them.
  logic [31:0] src_ops_word;
  logic [31:0] gc_support_word;
  logic [31:0] id_limit_word;
  logic [31:0] gc_info_word;
  logic [31:0] port_info_word;
  logic [7:0] port_index;

  // Source operations word: only the event write source bit is set.
  // event write capable.
  always_comb begin
    src_ops_word = 32'h00000000;
    src_ops_word[`SRC_OPS_EVENT_WRITE_BIT] = 1'h1;
  end

  // Group-cast support word, zero apart from its one defined bit.
  // basic group-cast absent.
  always_comb begin
    gc_support_word = 32'h00000000;
    gc_support_word[`GROUP_CAST_BASIC_BIT] = `BASIC_GROUP_CAST_CAP;
  end

  // Route limit word with its upper half reserved.
  // route ID limit.
  assign id_limit_word = {16'h0000, `ROUTE_ID_LIMIT};

  // Group-cast information word, all of it fixed.
  // mask count.
  assign gc_info_word = {`BLOCK_ASSOC_CAP, `PER_INGRESS_ASSOC_CAP,
                         `GROUP_CAST_IDS_PER_MASK, `GROUP_CAST_MASK_COUNT};

  // Port index of the access path, taken with the read request.
  // report the access path.
  assign port_index = req.via_two_wire ? `TWO_WIRE_PORT_INDEX
                                       : req.ingress_port;

  // Switch port information word.
  // upper half reserved.
  assign port_info_word = {16'h0000, `PORT_TOTAL, port_index};

  // Writable words as they read back; reserved bits are zero, whatever
  // value software last wrote into them.
  logic [31:0] init_id_word;
  logic [31:0] id_sel_word;
  logic [31:0] port_sel_word;

  assign init_id_word = {16'h0000, initializer_id_q};
  assign id_sel_word = {sel_ext_en_q, 11'h000, sel_port_tbl_q,
                        sel_high_q, sel_low_q};

  // Table index of each entry covered by the port-select word. The
  // selector byte wraps so that ID plus three stays inside the table.
  // The high ID byte takes no part in the index.
  logic [11:0] entry_idx [ENTRIES];
  logic [7:0] entry_id [ENTRIES];

  generate
    for (genvar k = 0; k < ENTRIES; k++) begin : g_entry
      assign entry_id[k] = sel_low_q + 8'(k);
      assign entry_idx[k] = {sel_port_tbl_q, entry_id[k]};
      assign port_sel_word[8*k +: 8] = route_tbl[entry_idx[k]];
    end
  endgenerate

  // Read multiplexer; unmapped addresses return zero. The decode strobes
  // are one-hot, so the order of the chain sets no priority.
  logic [31:0] rd_mux;

  assign rd_mux = hit_port_info ? port_info_word :
                  hit_src_ops ? src_ops_word :
                  hit_gc_support ? gc_support_word :
                  hit_id_limit ? id_limit_word :
                  hit_gc_info ? gc_info_word :
                  hit_init_id ? init_id_word :
                  hit_label ? device_label_q :
                  hit_id_sel ? id_sel_word :
                  hit_port_sel ? port_sel_word :
                  32'h00000000;

  // Initializer ID; only the low half of the write data is kept.
  // initializer ID field.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      initializer_id_q <= `INITIALIZER_ID_RESET;
    end else if (wr_init_id) begin
      initializer_id_q <= req.wdata[15:0];
    end
  end

  // Device label, stored whole.
  // device label.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      device_label_q <= `DEVICE_LABEL_RESET;
    end else if (wr_label) begin
      device_label_q <= req.wdata;
    end
  end

  // Destination ID select bytes. The reserved bits of the write data are
  // dropped here, so they always read back as zero.
  // low ID byte.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sel_low_q <= `ROUTE_SEL_RESET;
      sel_high_q <= `ROUTE_SEL_RESET;
    end else if (wr_id_sel) begin
      sel_low_q <= req.wdata[`ID_SEL_LOW_LSB +: 8];
      sel_high_q <= req.wdata[`ID_SEL_HIGH_LSB +: 8];
    end
  end

  // Port table selector and extended enable share the select write.
  // port table selector.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sel_port_tbl_q <= `PORT_TABLE_SEL_RESET;
      sel_ext_en_q <= `EXT_ENABLE_RESET;
    end else if (wr_id_sel) begin
      sel_port_tbl_q <= req.wdata[`ID_SEL_PORT_TBL_LSB +: 4];
      sel_ext_en_q <= req.wdata[`ID_SEL_EXT_EN_BIT];
    end
  end

  // Route entries. All four bytes of a port-select write land in one
  // cycle, so a following read of the same selection sees them at once.
  // byte zero egress.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < TOTAL; i++) begin
        route_tbl[i] <= `ROUTE_ENTRY_RESET;
      end
    end else if (wr_port_sel) begin
      for (int k = 0; k < ENTRIES; k++) begin
        route_tbl[entry_idx[k]] <= req.wdata[8*k +: 8];
      end
    end
  end

  // Read answer, registered, one cycle after the read request. A read
  // and a write in the same cycle return the value from before the write,
  // because the multiplexer looks at the registers ahead of the edge.
  logic rsp_valid_q;
  logic [31:0] rsp_rdata_q;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rsp_valid_q <= 1'h0;
      rsp_rdata_q <= 32'h00000000;
    end else begin
      rsp_valid_q <= req.rd;
      rsp_rdata_q <= req.rd ? rd_mux : 32'h00000000;
    end
  end

  // Lookup for the switch fabric, registered like the other data outputs.
  // An entry written in one cycle shows up here two cycles later.
  logic [7:0] lookup_egress_q;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lookup_egress_q <= `ROUTE_ENTRY_RESET;
    end else begin
      lookup_egress_q <= route_tbl[{lookup_table, lookup_id}];
    end
  end

  // Outputs.
  assign rsp.valid = rsp_valid_q;
  assign rsp.rdata = rsp_rdata_q;
  assign route_sel.ext_enable = sel_ext_en_q;
  assign route_sel.port_table = sel_port_tbl_q;
  assign route_sel.id_high = sel_high_q;
  assign route_sel.id_low = sel_low_q;
  assign initializer_id = initializer_id_q;
  assign device_label = device_label_q;
  assign lookup_egress = lookup_egress_q;

endmodule

/* File: pkg/route_cfg_defines.svh */
// Offsets, field positions, reset values and fixed capability values.
`ifndef ROUTE_CFG_DEFINES_SVH
`define ROUTE_CFG_DEFINES_SVH

// Register byte offsets.
`define OFS_SWITCH_PORT_INFO 24'h000014
`define OFS_SOURCE_OPS_CAPS 24'h000018
`define OFS_GROUP_CAST_SUPPORT_CAPS 24'h000030
`define OFS_ROUTE_ID_LIMIT_CAPS 24'h000034
`define OFS_GROUP_CAST_INFO_CAPS 24'h000038
`define OFS_INITIALIZER_ID_LOCK 24'h000068
`define OFS_DEVICE_LABEL 24'h00006c
`define OFS_ROUTE_CFG_ID_SELECT 24'h000070
`define OFS_ROUTE_CFG_PORT_SELECT 24'h000074

// Fixed capability fields.
`define SRC_OPS_EVENT_WRITE_BIT 2
`define GROUP_CAST_BASIC_BIT 31
`define BASIC_GROUP_CAST_CAP 1'h0
`define ROUTE_ID_LIMIT 16'h00ff
`define GROUP_CAST_MASK_COUNT 16'h0028
`define GROUP_CAST_IDS_PER_MASK 14'h00ff
`define PER_INGRESS_ASSOC_CAP 1'h0
`define BLOCK_ASSOC_CAP 1'h0
`define PORT_TOTAL 8'h10
`define TWO_WIRE_PORT_INDEX 8'hfe

// Reset values of the writable fields.
`define INITIALIZER_ID_RESET 16'hffff
`define DEVICE_LABEL_RESET 32'h00000000
`define ROUTE_SEL_RESET 8'h00
`define EXT_ENABLE_RESET 1'h0
`define PORT_TABLE_SEL_RESET 4'h0
`define ROUTE_ENTRY_RESET 8'h00

// Field positions in the destination-ID select register.
`define ID_SEL_LOW_LSB 0
`define ID_SEL_HIGH_LSB 8
`define ID_SEL_PORT_TBL_LSB 16
`define ID_SEL_EXT_EN_BIT 31

// Number of route entries reached by one port-select access.
`define ROUTE_ENTRIES_PER_WORD 4

`endif

/* File: pkg/route_cfg_pkg.sv */
// Types shared by the route configuration register bank.
package route_cfg_pkg;

  // One register access from the maintenance or two-wire side.
  typedef struct packed {
    logic rd;
    logic wr;
    logic via_two_wire;
    logic [7:0] ingress_port;
    logic [23:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  // The answer to a read, valid one cycle after the request.
  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } reg_rsp_t;

  // The current route-table selection seen by the switch fabric.
  typedef struct packed {
    logic ext_enable;
    logic [3:0] port_table;
    logic [7:0] id_high;
    logic [7:0] id_low;
  } route_sel_t;

endpackage

/* File: testbench/route_cfg_regs_assertions.sv */
// Checker of the register bank's answers and stored fields.
`include "route_cfg_defines.svh"
module route_cfg_regs_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire route_cfg_pkg::reg_req_t req,
  input wire route_cfg_pkg::reg_rsp_t rsp,
  input wire route_cfg_pkg::route_sel_t route_sel,
  input wire logic [15:0] initializer_id,
  input wire logic [31:0] device_label,
  input wire logic [7:0] lookup_id,
  input wire logic [3:0] lookup_table,
  input wire logic [7:0] lookup_egress
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Offset of the current request.
  logic [23:0] a;
  assign a = req.addr;
  a_src_ops_word: assert property (
    req.rd && a == `OFS_SOURCE_OPS_CAPS |=> rsp.valid && rsp.rdata == 32'h4)
    else $error("source ops word wrong");
  a_gc_support_zero: assert property (
    req.rd && a == `OFS_GROUP_CAST_SUPPORT_CAPS |=> rsp.rdata == 32'h0)
    else $error("group-cast support word wrong");
  a_id_limit_word: assert property (
    req.rd && a == `OFS_ROUTE_ID_LIMIT_CAPS |=> rsp.rdata == 32'hff)
    else $error("route limit word wrong");
  a_gc_info_word: assert property (
    req.rd && a == `OFS_GROUP_CAST_INFO_CAPS |=> rsp.rdata == 32'h00ff0028)
    else $error("group-cast info word wrong");
  a_port_info_word: assert property (
    req.rd && a == `OFS_SWITCH_PORT_INFO |=> rsp.valid && rsp.rdata ==
    {16'h0, 8'h10, $past(req.via_two_wire) ? 8'hfe : $past(req.ingress_port)})
    else $error("port info word wrong");
  a_init_id_read: assert property (
    req.rd && a == `OFS_INITIALIZER_ID_LOCK
    |=> rsp.rdata == {16'h0, $past(initializer_id)})
    else $error("initializer id readback wrong");
  a_init_id_write: assert property (
    req.wr && a == `OFS_INITIALIZER_ID_LOCK
    |=> initializer_id == $past(req.wdata[15:0]))
    else $error("initializer id not written");
  a_label_write: assert property (
    req.wr && a == `OFS_DEVICE_LABEL |=> device_label == $past(req.wdata))
    else $error("device label not written");
  a_sel_write: assert property (
    req.wr && a == `OFS_ROUTE_CFG_ID_SELECT
    |=> route_sel == {$past(req.wdata[31]), $past(req.wdata[19:0])})
    else $error("select fields not written");
  a_sel_holds: assert property (
    !(req.wr && a == `OFS_ROUTE_CFG_ID_SELECT) |=> $stable(route_sel))
    else $error("select fields changed without write");
  // Main traffic shapes that the bench must reach.
  c_port_write: cover property (req.wr && a == `OFS_ROUTE_CFG_PORT_SELECT);
  c_rd_wr_same: cover property (req.rd && req.wr);
  c_two_wire_rd: cover property (req.rd && req.via_two_wire);
endmodule

bind route_cfg_regs route_cfg_regs_checker u_chk (.clk(clk), .resetn(resetn),
  .req(req), .rsp(rsp), .route_sel(route_sel),
  .initializer_id(initializer_id), .device_label(device_label),
  .lookup_id(lookup_id), .lookup_table(lookup_table),
  .lookup_egress(lookup_egress));

/* File: testbench/tb_top.sv */
// Self-checking bench for the route configuration register bank.
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  route_cfg_pkg::reg_req_t req = '0;
  route_cfg_pkg::reg_rsp_t rsp;
  route_cfg_pkg::route_sel_t route_sel;
  logic [15:0] initializer_id;
  logic [31:0] device_label;
  logic [7:0] lookup_id = 8'h00;
  logic [3:0] lookup_table = 4'h0;
  logic [7:0] lookup_egress;
  int err_total = 0;
  int check_count = 0;
  int seed = 32'h924ebe80;
  logic [15:0] m_id = 16'hffff;
  logic [31:0] m_label = 32'h0;
  logic [31:0] m_sel = 32'h0;
  logic [31:0] d;
  logic [7:0] m_tbl [16][256];
  logic [23:0] ofs [10] = '{24'h14, 24'h18, 24'h30, 24'h34, 24'h38, 24'h68,
    24'h6c, 24'h70, 24'h74, 24'h40};

  // Clock of 5 ns period.
  always #2.5 clk = ~clk;

  route_cfg_regs u_dut (.clk(clk), .resetn(resetn), .req(req), .rsp(rsp),
    .route_sel(route_sel), .initializer_id(initializer_id),
    .device_label(device_label), .lookup_id(lookup_id),
    .lookup_table(lookup_table), .lookup_egress(lookup_egress));

  // Expected read word from the bench's own copy of the registers.
  function automatic logic [31:0] exp_rd(logic [23:0] a);
    logic [3:0] t;
    logic [7:0] i;
    t = m_sel[19:16];
    i = m_sel[7:0];
    case (a)
      24'h14: return {16'h0, 8'h10,
        req.via_two_wire ? 8'hfe : req.ingress_port};
      24'h18: return 32'h00000004;
      24'h34: return 32'h000000ff;
      24'h38: return 32'h00ff0028;
      24'h68: return {16'h0, m_id};
      24'h6c: return m_label;
      24'h70: return m_sel;
      24'h74: return {m_tbl[t][i + 8'd3], m_tbl[t][i + 8'd2],
        m_tbl[t][i + 8'd1], m_tbl[t][i]};
      default: return 32'h0;
    endcase
  endfunction

  task automatic mdl_wr(logic [23:0] a, logic [31:0] v);
    if (a == 24'h68) m_id = v[15:0];
    if (a == 24'h6c) m_label = v;
    if (a == 24'h70) m_sel = v & 32'h800fffff;
    if (a == 24'h74)
      for (int k = 0; k < 4; k++)
        m_tbl[m_sel[19:16]][m_sel[7:0] + k[7:0]] = v[8*k +: 8];
  endtask

  // One access; the expectation is taken before the edge that takes it.
  task automatic acc(logic r, logic w, logic [23:0] a, logic [31:0] v);
    logic [31:0] e;
    @(negedge clk);
    d = $random(seed);
    req.via_two_wire = d[0];
    req.ingress_port = d[15:8];
    req.rd = r;
    req.wr = w;
    req.addr = a;
    req.wdata = v;
    e = exp_rd(a);
    if (w) mdl_wr(a, v);
    @(negedge clk);
    // The answer stands only from the taking edge to the next one.
    if (r) begin
      `CHK(rsp.valid, 1'b1)
      `CHK(rsp.rdata, e)
    end else begin
      `CHK(rsp.valid, 1'b0)
    end
    req.rd = 1'b0;
    req.wr = 1'b0;
    `CHK(initializer_id, m_id)
    `CHK(device_label, m_label)
    `CHK(route_sel, {m_sel[31], m_sel[19:0]})
  endtask

  // Fabric lookup of one stored entry.
  task automatic look(logic [3:0] t, logic [7:0] i);
    @(negedge clk);
    lookup_table = t;
    lookup_id = i;
    @(negedge clk);
    `CHK(lookup_egress, m_tbl[t][i])
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Reset, fixed words, write refusal, wrap, same-cycle access, random mix.
  initial begin
    foreach (m_tbl[t, i]) m_tbl[t][i] = 8'h00;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    foreach (ofs[j]) acc(1'b1, 1'b0, ofs[j], 32'h0);
    foreach (ofs[j]) acc(1'b0, 1'b1, ofs[j], 32'hffffffff);
    foreach (ofs[j]) acc(1'b1, 1'b0, ofs[j], 32'h0);
    // entries wrap past the table top.
    acc(1'b0, 1'b1, 24'h70, 32'h800a00fe);
    acc(1'b1, 1'b1, 24'h74, 32'h44332211);
    look(4'ha, 8'h01);
    look(4'ha, 8'hfe);
    acc(1'b1, 1'b1, 24'h6c, 32'h12345678);
    repeat (300) begin
      d = $random(seed);
      acc(d[0], d[1], ofs[int'(d[7:4]) % 10], $random(seed));
      look(m_sel[19:16], m_sel[7:0] + {6'h0, d[9:8]});
    end
    print_verdict;
  end
endmodule
